// ===== design/hdlc_rx_ctrl.v
// HDLC receive controller: flag hunt, destuffing, CRC check and tagged receive FIFO
//
// Summary of operation
// - Receive FIFO holds 256 packet bytes
// - C-bit mode uses subframe five C-bits
// - E3 receives Sn; transmit Sn when selected
// - M23 mode disconnects the controller
// - Reset flushes FIFO and restarts hunt
// - Hunt bitwise, destuff, align, store bytes
// - First packet byte carries opening marker
// - Closing flag checks CRC, marks last byte
// - Check sequence bytes never enter FIFO
// - Closing byte carries two-bit packet status
// - Single or shared-zero flags delimit packets
// - Overflow drops packet rest, latches overrun
// - After overflow refuse until empty or reset
// - Seven ones latch abort seen flag
// - Mid-packet abort recorded in packet status
// - Latch packet start and packet end events
// - High watermark when occupancy exceeds threshold
// - Each data read of a non-empty FIFO pops one byte
// - Empty flag shown in information register
// - Reset control rising edge resets receiver
// - Invert control inverts whole receive stream
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "hdlc_rx_regs.vh"
module hdlc_rx_ctrl #(
  parameter AW = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire nrst,
  // Framer overhead bit stream
  input wire [1:0] frmMode,
  input wire cbitIn,
  input wire cbitValid,
  input wire snIn,
  input wire snValid,
  input wire [1:0] snSourceSel,
  // Transmit overhead insertion controls
  output reg txCbitInsert_r,
  output reg txSnInsert_r,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData_r
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rstMeta_r; // First stage
  reg rstN_r; // Synchronised reset

  // Release through two flops so all logic leaves reset on one edge
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_r <= 1'b0;
      rstN_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstN_r <= rstMeta_r;
    end
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg ctrlRst_r, rstPrev_r, ctrlInv_r; // Control bits
  reg [2:0] wmSel_r; // Watermark select
  reg ovrL_r, peL_r, psL_r, abtL_r, hwmL_r; // Latched status
  reg hwmPrev_r; // Watermark history
  reg [2:0] ones_r, ones_nxt; // Run of ones
  reg inFrame_r, inFrame_nxt; // Between flags
  reg [6:0] dly_r, dly_nxt; // Flag lookahead line
  reg [2:0] dlyCnt_r, dlyCnt_nxt;
  reg [7:0] asm_r, asm_nxt; // Byte assembly
  reg [2:0] asmCnt_r, asmCnt_nxt;
  reg [23:0] hold_r, hold_nxt; // Three byte hold
  reg [1:0] holdCnt_r, holdCnt_nxt;
  reg [15:0] crc_r, crc_nxt; // Running check
  reg wrote_r, wrote_nxt; // Packet has bytes stored
  reg drop_r, drop_nxt; // Discard rest of packet
  reg refuse_r; // Blocked after overflow
  reg [AW:0] wrPtr_r, rdPtr_r; // FIFO pointers
  reg fWe; // Write request
  reg [11:0] fData; // {status, close, open, byte}
  reg abortEv; // Abort seen this bit
  reg [1:0] closeSt; // Status for closing byte
  wire softRst; // Reset trigger edge
  wire bitValid; // Overhead bit present
  wire rawBit; // Selected overhead bit
  wire bitIn; // Bit after optional inversion
  wire [AW:0] level; // Occupancy
  wire full, empty;
  wire doWrite, ovrEv, pop;
  wire [AW:0] rdPtrNxt;
  wire [AW:0] threshold;
  wire hwmLive;
  wire [11:0] memQ; // Head entry
  wire [7:0] newByte;

  // ----------------------------------------
  // Stream selection
  // ----------------------------------------
  // C-bit source in C-bit mode, Sn source in E3 mode
  assign bitValid = ((frmMode == `HR_MODE_CBIT) && cbitValid) || ((frmMode == `HR_MODE_E3) && snValid);
  assign rawBit = (frmMode == `HR_MODE_CBIT) ? cbitIn : snIn;
  assign bitIn = rawBit ^ ctrlInv_r;

  assign softRst = ctrlRst_r & ~rstPrev_r;

  // ----------------------------------------
  // FIFO bookkeeping
  // ----------------------------------------
  // depth of 256 entries
  assign level = wrPtr_r - rdPtr_r;
  assign full = level[AW];
  assign empty = (level == {(AW+1){1'b0}});
  assign ovrEv = fWe & full;
  assign doWrite = fWe & ~full;
  assign pop = regRd && (regAddr == `HR_DATA_OFS) && !empty;
  assign rdPtrNxt = softRst ? wrPtr_r : (rdPtr_r + {{AW{1'b0}}, pop});
  assign threshold = {1'b0, wmSel_r, 5'h00};
  assign hwmLive = (level > threshold);
  assign newByte = {dly_r[0], asm_r[7:1]};

  // Storage; address runs one step ahead so back-to-back pops see fresh data
  hdlc_rx_mem #(
    .WIDTH(12),
    .AW(AW)
  ) uMem (
    .clk(clk_sys),
    .we(doWrite),
    .wrAddr(wrPtr_r[AW-1:0]),
    .wrData(fData),
    .rdAddr(rdPtrNxt[AW-1:0]),
    .rdData(memQ)
  );

  // ----------------------------------------
  // Bit processing
  // ----------------------------------------
  // Seven lookahead bits hold a would-be flag until its last zero proves it
  always @*
  begin
    ones_nxt = ones_r;
    inFrame_nxt = inFrame_r;
    dly_nxt = dly_r;
    dlyCnt_nxt = dlyCnt_r;
    asm_nxt = asm_r;
    asmCnt_nxt = asmCnt_r;
    hold_nxt = hold_r;
    holdCnt_nxt = holdCnt_r;
    crc_nxt = crc_r;
    wrote_nxt = wrote_r;
    drop_nxt = drop_r;
    fWe = 1'b0;
    fData = 12'h000;
    abortEv = 1'b0;
    if (asmCnt_r != 3'h0)
    begin
      closeSt = `HR_PS_ALIGN;
    end
    else if (crc_r != `HR_CRC_GOOD)
    begin
      closeSt = `HR_PS_CRC;
    end
    else
    begin
      closeSt = `HR_PS_GOOD;
    end
    if (bitValid)
    begin
      // Count ones, saturating at seven
      if (bitIn)
      begin
        ones_nxt = (ones_r == 3'h7) ? 3'h7 : (ones_r + 3'h1);
      end
      else
      begin
        ones_nxt = 3'h0;
      end
      if (bitIn && (ones_r == `HR_FLAG_ONES))
      begin
        abortEv = 1'b1;
        inFrame_nxt = 1'b0;
        wrote_nxt = 1'b0;
        // Hold empties so a later abort cannot store a stale byte
        holdCnt_nxt = 2'h0;
        // abort closes stored packet
        // Only the oldest held byte survives; one write per bit keeps the FIFO port simple
        if ((holdCnt_r == 2'h3) && !drop_r)
        begin
          fWe = 1'b1;
          fData = {`HR_PS_ABORT, 1'b1, ~wrote_r, hold_r[23:16]};
        end
      end
      else if (!bitIn && (ones_r == `HR_FLAG_ONES))
      begin
        // status beside closing marker
        // A full hold means at least one data byte; a one-byte packet is both opening and closing
        if ((holdCnt_r == 2'h3) && !drop_r)
        begin
          fWe = 1'b1;
          fData = {closeSt, 1'b1, ~wrote_r, hold_r[23:16]};
        end
        // closing zero may also open the next flag
        // Line starts empty: the zero is never data, and six ones plus a zero still match
        inFrame_nxt = 1'b1;
        dly_nxt = 7'h00;
        dlyCnt_nxt = 3'h0;
        asmCnt_nxt = 3'h0;
        holdCnt_nxt = 2'h0;
        crc_nxt = `HR_CRC_INIT;
        wrote_nxt = 1'b0;
        drop_nxt = refuse_r;
      end
      else if (!bitIn && (ones_r == `HR_STUFF_ONES))
      begin
        dly_nxt = dly_r;
      end
      else if (inFrame_r)
      begin
        dly_nxt = {bitIn, dly_r[6:1]};
        if (dlyCnt_r != 3'h7)
        begin
          dlyCnt_nxt = dlyCnt_r + 3'h1;
        end
        else
        begin
          // Bit leaving the line is real data or check sequence
          crc_nxt = {1'b0, crc_r[15:1]} ^ ((crc_r[0] ^ dly_r[0]) ? `HR_CRC_POLY : 16'h0000);
          asm_nxt = newByte;
          asmCnt_nxt = asmCnt_r + 3'h1;
          if (asmCnt_r == 3'h7)
          begin
            hold_nxt = {hold_r[15:0], newByte};
            // last two bytes held back as check sequence
            if (holdCnt_r != 2'h3)
            begin
              holdCnt_nxt = holdCnt_r + 2'h1;
            end
            else if (!drop_r)
            begin
              fWe = 1'b1;
              fData = {`HR_PS_GOOD, 1'b0, ~wrote_r, hold_r[23:16]};
              wrote_nxt = 1'b1;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Receiver state
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstN_r)
  begin
    if (!rstN_r)
    begin
      ones_r <= 3'h0;
      inFrame_r <= 1'b0;
      dly_r <= 7'h00;
      dlyCnt_r <= 3'h0;
      asm_r <= 8'h00;
      asmCnt_r <= 3'h0;
      hold_r <= 24'h000000;
      holdCnt_r <= 2'h0;
      crc_r <= `HR_CRC_INIT;
      wrote_r <= 1'b0;
      drop_r <= 1'b0;
      refuse_r <= 1'b0;
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
    end
    else if (softRst)
    begin
      ones_r <= 3'h0;
      inFrame_r <= 1'b0;
      dlyCnt_r <= 3'h0;
      asmCnt_r <= 3'h0;
      holdCnt_r <= 2'h0;
      wrote_r <= 1'b0;
      drop_r <= 1'b0;
      refuse_r <= 1'b0;
      rdPtr_r <= rdPtrNxt;
    end
    else
    begin
      ones_r <= ones_nxt;
      inFrame_r <= inFrame_nxt;
      dly_r <= dly_nxt;
      dlyCnt_r <= dlyCnt_nxt;
      asm_r <= asm_nxt;
      asmCnt_r <= asmCnt_nxt;
      hold_r <= hold_nxt;
      holdCnt_r <= holdCnt_nxt;
      crc_r <= crc_nxt;
      wrote_r <= wrote_nxt;
      drop_r <= drop_nxt | ovrEv;
      refuse_r <= ovrEv | (refuse_r & ~empty);
      wrPtr_r <= wrPtr_r + {{AW{1'b0}}, doWrite};
      rdPtr_r <= rdPtrNxt;
    end
  end

  // ----------------------------------------
  // Control and latched status
  // ----------------------------------------
  // Latches are write-one-to-clear; a new event in the same cycle wins
  always @(posedge clk_sys or negedge rstN_r)
  begin
    if (!rstN_r)
    begin
      ctrlRst_r <= `HR_CTRL_RST;
      rstPrev_r <= 1'b0;
      ctrlInv_r <= `HR_CTRL_RST;
      wmSel_r <= `HR_WMRK_RST;
      ovrL_r <= 1'b0;
      peL_r <= 1'b0;
      psL_r <= 1'b0;
      abtL_r <= 1'b0;
      hwmL_r <= 1'b0;
      hwmPrev_r <= 1'b0;
      txCbitInsert_r <= 1'b0;
      txSnInsert_r <= 1'b0;
    end
    else
    begin
      rstPrev_r <= ctrlRst_r;
      hwmPrev_r <= hwmLive;
      if (regWr && (regAddr == `HR_CTRL_OFS))
      begin
        ctrlRst_r <= regWrData[`HR_RST_BIT];
        ctrlInv_r <= regWrData[`HR_INV_BIT];
      end
      if (regWr && (regAddr == `HR_WMRK_OFS))
      begin
        wmSel_r <= regWrData[`HR_WM_LSB+2:`HR_WM_LSB];
      end
      ovrL_r <= ovrEv | (ovrL_r & ~(regWr && (regAddr == `HR_LTCH_OFS) && regWrData[`HR_OVR_BIT]));
      peL_r <= (doWrite & fData[9]) | (peL_r & ~(regWr && (regAddr == `HR_LTCH_OFS) && regWrData[`HR_PE_BIT]));
      psL_r <= (doWrite & fData[8]) | (psL_r & ~(regWr && (regAddr == `HR_LTCH_OFS) && regWrData[`HR_PS_BIT]));
      abtL_r <= abortEv | (abtL_r & ~(regWr && (regAddr == `HR_LTCH_OFS) && regWrData[`HR_ABT_BIT]));
      hwmL_r <= (hwmLive & ~hwmPrev_r) | (hwmL_r & ~(regWr && (regAddr == `HR_LTCH_OFS) && regWrData[`HR_HWM_BIT]));
      // C-bit insertion only in C-bit mode
      txCbitInsert_r <= (frmMode == `HR_MODE_CBIT);
      txSnInsert_r <= (frmMode == `HR_MODE_E3) && (snSourceSel == `HR_SN_HDLC);
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  // Data stands one cycle after the strobe; unmapped offsets read zero
  always @(posedge clk_sys or negedge rstN_r)
  begin
    if (!rstN_r)
    begin
      regRdData_r <= 8'h00;
    end
    else if (regRd)
    begin
      case (regAddr)
        `HR_CTRL_OFS:
        begin
          regRdData_r <= {ctrlRst_r, 1'b0, ctrlInv_r, 5'h00};
        end
        `HR_WMRK_OFS:
        begin
          regRdData_r <= {1'b0, wmSel_r, 4'h0};
        end
        `HR_STAT_OFS:
        begin
          regRdData_r <= {4'h0, hwmLive, 3'h0};
        end
        `HR_LTCH_OFS:
        begin
          regRdData_r <= {ovrL_r, peL_r, psL_r, abtL_r, hwmL_r, 3'h0};
        end
        `HR_INFO_OFS:
        begin
          regRdData_r <= {2'h0, empty, 5'h00};
        end
        `HR_DATA_OFS:
        begin
          regRdData_r <= empty ? 8'h00 : memQ[7:0];
        end
        `HR_TAGS_OFS:
        begin
          // status and markers of head byte
          regRdData_r <= empty ? 8'h00 : {4'h0, memQ[11:8]};
        end
        default:
        begin
          regRdData_r <= 8'h00;
        end
      endcase
    end
  end

endmodule // hdlc_rx_ctrl

// ===== design/hdlc_rx_mem.v
// Receive FIFO storage with a registered read port
`timescale 1ns/10ps
module hdlc_rx_mem #(
  parameter WIDTH = 12,
  parameter AW = 8
) (
  // Clock
  input wire clk,
  // Write side
  input wire we,
  input wire [AW-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  // Read side
  input wire [AW-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData
);

  // Entry array, no reset: the pointers decide what is valid
  reg [WIDTH-1:0] store [0:(1<<AW)-1];

  // ----------------------------------------
  // Write, and read with write-through
  // ----------------------------------------
  // Bypass keeps a byte written into an empty FIFO visible at once
  always @(posedge clk)
  begin
    if (we)
    begin
      store[wrAddr] <= wrData;
    end
    if (we && (wrAddr == rdAddr))
    begin
      rdData <= wrData;
    end
    else
    begin
      rdData <= store[rdAddr];
    end
  end

endmodule // hdlc_rx_mem

// ===== design/hdlc_rx_regs.vh
// Register offsets, field positions, codes and reset values of the HDLC receive controller
`ifndef HDLC_RX_REGS_VH
`define HDLC_RX_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HR_CTRL_OFS 8'h50
`define HR_WMRK_OFS 8'h51
`define HR_STAT_OFS 8'h54
`define HR_LTCH_OFS 8'h55
`define HR_INFO_OFS 8'h57
`define HR_DATA_OFS 8'h5c
`define HR_TAGS_OFS 8'h5d
// ----------------------------------------
// Field positions
// ----------------------------------------
`define HR_RST_BIT 7
`define HR_INV_BIT 5
`define HR_WM_LSB 4
`define HR_OVR_BIT 7
`define HR_PE_BIT 6
`define HR_PS_BIT 5
`define HR_ABT_BIT 4
`define HR_HWM_BIT 3
`define HR_EMPTY_BIT 5
`define HR_WM_SHIFT 5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define HR_CTRL_RST 1'h0
`define HR_WMRK_RST 3'h0
// ----------------------------------------
// Framer modes and Sn source code
// ----------------------------------------
`define HR_MODE_M23 2'h0
`define HR_MODE_CBIT 2'h1
`define HR_MODE_E3 2'h2
`define HR_SN_HDLC 2'h1
// ----------------------------------------
// Packet status codes and line constants
// ----------------------------------------
`define HR_PS_GOOD 2'h0
`define HR_PS_CRC 2'h1
`define HR_PS_ABORT 2'h2
`define HR_PS_ALIGN 2'h3
`define HR_CRC_INIT 16'hffff
`define HR_CRC_POLY 16'h8408
`define HR_CRC_GOOD 16'hf0b8
`define HR_FLAG_ONES 3'h6
`define HR_STUFF_ONES 3'h5
`endif

// ===== verif/hdlc_rx_ctrl_asserts.sv
// Port-level checks for the HDLC receive controller
`timescale 1ns/10ps
module hdlc_rx_ctrl_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Framer controls and transmit insertion
  input wire logic [1:0] frmMode,
  input wire logic [1:0] snSourceSel,
  input wire logic txCbitInsert_r,
  input wire logic txSnInsert_r,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData_r
);
  logic [2:0] live_r;  // Settle count; internal reset lags nrst by two flops
  logic rstBit_r;      // Last written reset trigger bit
  // Track settling and the reset trigger history
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      live_r <= 3'h0;
      rstBit_r <= 1'b0;
    end
    else
    begin
      if (!live_r[2])
        live_r <= live_r + 3'h1;
      if (regWr && regAddr == 8'h50)
        rstBit_r <= regWrData[7];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!live_r[2]);
  // Rising trigger write, then an information read two cycles on
  sequence softRst;
    regWr && regAddr == 8'h50 && regWrData[7] && !rstBit_r;
  endsequence
  sequence infoRd;
    regRd && regAddr == 8'h57;
  endsequence
  flush_empty_a: assert property (softRst ##2 infoRd |=> regRdData_r[5])
    else $error("receive reset left FIFO not empty");
  cbit_insert_a: assert property (txCbitInsert_r == ($past(frmMode) == 2'h1))
    else $error("C-bit insert wrong for mode");
  sn_insert_a: assert property (txSnInsert_r == ($past(frmMode) == 2'h2 && $past(snSourceSel) == 2'h1))
    else $error("Sn insert wrong for mode or select");
  m23_idle_a: assert property (frmMode == 2'h0 |=> !txCbitInsert_r && !txSnInsert_r)
    else $error("controller active in M23 mode");
  unmapped_zero_a: assert property (regRd && !(regAddr inside {8'h50, 8'h51, 8'h54, 8'h55, 8'h57, 8'h5c, 8'h5d})
    |=> regRdData_r == 8'h00) else $error("unmapped read not zero");
  tag_field_a: assert property (regRd && regAddr == 8'h5d |=> regRdData_r[7:4] == 4'h0)
    else $error("tag read has upper bits set");
  read_hold_a: assert property (!regRd |=> $stable(regRdData_r))
    else $error("read data moved without a read");
  live_wmark_a: assert property (regRd && regAddr == 8'h54 |=> (regRdData_r & 8'hf7) == 8'h00)
    else $error("live status has stray bits");
endmodule // hdlc_rx_ctrl_asserts

// ===== verif/overhead_bit_source.sv
// Framer overhead bit source feeding HDLC bits on the C-bit or Sn lane
`timescale 1ns/10ps
module overhead_bit_source (
  // Clock
  input wire logic clk_sys,
  // Lane select (0 C-bit, 1 Sn) and inversion
  input wire logic lane,
  input wire logic inv,
  // Overhead bits
  output logic cbitIn = 1'b0,
  output logic cbitValid = 1'b0,
  output logic snIn = 1'b0,
  output logic snValid = 1'b0
);
  logic [15:0] crc;  // Running check sequence
  int ones;          // Ones run, drives zero stuffing
  // one pulse on the chosen lane
  task automatic put(input logic b);
    @(posedge clk_sys);
    cbitValid <= !lane;
    snValid <= lane;
    cbitIn <= b ^ inv;
    snIn <= b ^ inv;
    @(posedge clk_sys);
    cbitValid <= 1'b0;
    snValid <= 1'b0;
    // Idle lines flip so a stale bit can never look valid
    cbitIn <= !(b ^ inv);
    snIn <= !(b ^ inv);
  endtask
  // flag, optionally sharing the previous closing zero
  task automatic flag(input logic share);
    for (int i = share; i < 8; i++)
      put(i != 0 && i != 7);
    ones = 0;
  endtask
  // Byte LSB first with zero stuffing and optional CRC fold
  task automatic byte_out(input logic [7:0] d, input logic fold);
    for (int i = 0; i < 8; i++)
    begin
      put(d[i]);
      if (fold)
        crc = (crc >> 1) ^ ((crc[0] ^ d[i]) ? 16'h8408 : 16'h0000);
      ones = d[i] ? ones + 1 : 0;
      if (ones == 5)
      begin
        put(1'b0);
        ones = 0;
      end
    end
  endtask
  // Data, inverted FCS low byte first, closing flag; bad spoils the FCS
  task automatic packet(input logic [7:0] q[$], input logic bad);
    logic [15:0] f;
    crc = 16'hffff;
    ones = 0;
    foreach (q[i])
      byte_out(q[i], 1'b1);
    f = ~crc ^ {15'h0, bad};
    byte_out(f[7:0], 1'b0);
    byte_out(f[15:8], 1'b0);
    flag(1'b0);
  endtask
  task automatic abort_run;
    repeat (8) put(1'b1);
    ones = 0;
  endtask
endmodule // overhead_bit_source

// ===== verif/testbench.sv
// Self-checking bench for the HDLC receive controller
`timescale 1ns/10ps
module testbench;
  // Stimulus, defined from time zero
  logic clk_sys, nrst, regWr, regRd, lane, inv;
  logic [1:0] frmMode, snSourceSel;
  logic [7:0] regAddr, regWrData;
  logic cbitIn, cbitValid, snIn, snValid, txCbitInsert_r, txSnInsert_r;
  logic [7:0] regRdData_r;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] big[$];  // Oversized packet body
  // Rows: mode, Sn select, address, read value, tx C-bit, tx Sn
  typedef struct {logic [1:0] m, s; logic [7:0] a, d; logic c, n;} row_t;
  row_t rows[7] = '{'{2'h0, 2'h1, 8'h50, 8'h00, 1'b0, 1'b0}, '{2'h1, 2'h0, 8'h51, 8'h00, 1'b1, 1'b0},
    '{2'h2, 2'h1, 8'h54, 8'h00, 1'b0, 1'b1}, '{2'h2, 2'h0, 8'h55, 8'h00, 1'b0, 1'b0},
    '{2'h3, 2'h1, 8'h57, 8'h20, 1'b0, 1'b0}, '{2'h1, 2'h1, 8'h5c, 8'h00, 1'b1, 1'b0},
    '{2'h2, 2'h2, 8'h33, 8'h00, 1'b0, 1'b0}};
  always #4 clk_sys = !clk_sys;
  hdlc_rx_ctrl i_hdlc_rx_ctrl (.clk_sys(clk_sys), .nrst(nrst), .frmMode(frmMode), .cbitIn(cbitIn),
    .cbitValid(cbitValid), .snIn(snIn), .snValid(snValid), .snSourceSel(snSourceSel),
    .txCbitInsert_r(txCbitInsert_r), .txSnInsert_r(txSnInsert_r), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r));
  overhead_bit_source i_overhead_bit_source (.clk_sys(clk_sys), .lane(lane), .inv(inv), .cbitIn(cbitIn),
    .cbitValid(cbitValid), .snIn(snIn), .snValid(snValid));
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // Read; data stand from the cycle after the strobe until the next read
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), regRdData_r & m, e);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk_sys);
  endtask
  // Hang guard: whole run needs well under this many cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    frmMode = 2'h1;
    snSourceSel = 2'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    lane = 1'b0;
    inv = 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    foreach (rows[i])
    begin
      frmMode <= rows[i].m;
      snSourceSel <= rows[i].s;
      rdchk(rows[i].a, 8'hff, rows[i].d);
      chk("tx C-bit", {7'h0, txCbitInsert_r}, {7'h0, rows[i].c});
      chk("tx Sn", {7'h0, txSnInsert_r}, {7'h0, rows[i].n});
    end
    $display("test rows done");
    // Good two-byte packet on the C-bits
    frmMode <= 2'h1;
    i_overhead_bit_source.flag(1'b0);
    i_overhead_bit_source.packet('{8'ha5, 8'h3c}, 1'b0);
    settle();
    rdchk(8'h55, 8'h60, 8'h60);
    rdchk(8'h5d, 8'hff, 8'h01);
    rdchk(8'h5c, 8'hff, 8'ha5);
    rdchk(8'h5d, 8'hff, 8'h02);
    rdchk(8'h5c, 8'hff, 8'h3c);
    rdchk(8'h57, 8'hff, 8'h20);
    $display("test good packet done");
    // Inverted Sn stream: bad CRC packet, shared-zero flag, good packet
    frmMode <= 2'h2;
    lane <= 1'b1;
    inv <= 1'b1;
    wr(8'h50, 8'h20);
    i_overhead_bit_source.flag(1'b0);
    i_overhead_bit_source.packet('{8'h7e}, 1'b1);
    i_overhead_bit_source.flag(1'b1);
    i_overhead_bit_source.packet('{8'hc3}, 1'b0);
    settle();
    rdchk(8'h5d, 8'hff, 8'h07);
    rdchk(8'h5c, 8'hff, 8'h7e);
    rdchk(8'h5d, 8'hff, 8'h03);
    rdchk(8'h5c, 8'hff, 8'hc3);
    inv <= 1'b0;
    lane <= 1'b0;
    wr(8'h50, 8'h00);
    $display("test invert and shared flag done");
    // Abort after four bytes
    frmMode <= 2'h1;
    wr(8'h55, 8'hff);
    i_overhead_bit_source.flag(1'b0);
    foreach (rows[i])
      if (i < 4)
        i_overhead_bit_source.byte_out(8'h11 * (i + 1), 1'b0);
    i_overhead_bit_source.abort_run();
    i_overhead_bit_source.flag(1'b0);
    settle();
    rdchk(8'h55, 8'h10, 8'h10);
    rdchk(8'h5d, 8'hff, 8'h0b);
    rdchk(8'h5c, 8'hff, 8'h11);
    rdchk(8'h57, 8'hff, 8'h20);
    $display("test abort done");
    // M23 mode ignores the lanes entirely
    frmMode <= 2'h0;
    wr(8'h55, 8'hff);
    i_overhead_bit_source.flag(1'b0);
    i_overhead_bit_source.packet('{8'h44}, 1'b0);
    settle();
    rdchk(8'h57, 8'hff, 8'h20);
    rdchk(8'h55, 8'hff, 8'h00);
    $display("test M23 done");
    // Receive reset trigger flushes held bytes, latches stay
    frmMode <= 2'h1;
    i_overhead_bit_source.flag(1'b0);
    i_overhead_bit_source.packet('{8'h01, 8'h02}, 1'b0);
    settle();
    wr(8'h50, 8'h00);
    wr(8'h50, 8'h80);
    rdchk(8'h57, 8'hff, 8'h20);
    rdchk(8'h55, 8'h60, 8'h60);
    wr(8'h50, 8'h00);
    $display("test receive reset done");
    // Overflow with watermark 7 (threshold 224), refusal, drain, recovery
    for (int i = 0; i < 262; i++)
      big.push_back(i[7:0]);
    wr(8'h51, 8'h70);
    wr(8'h55, 8'hff);
    i_overhead_bit_source.flag(1'b0);
    i_overhead_bit_source.packet(big, 1'b0);
    settle();
    rdchk(8'h55, 8'h88, 8'h88);
    rdchk(8'h54, 8'h08, 8'h08);
    i_overhead_bit_source.flag(1'b0);
    i_overhead_bit_source.packet('{8'haa}, 1'b0);
    settle();
    rdchk(8'h5d, 8'hff, 8'h01);
    for (int i = 0; i < 256; i++)
      rdchk(8'h5c, 8'hff, i[7:0]);
    rdchk(8'h57, 8'hff, 8'h20);
    rdchk(8'h54, 8'hff, 8'h00);
    i_overhead_bit_source.flag(1'b0);
    i_overhead_bit_source.packet('{8'h5a}, 1'b0);
    settle();
    rdchk(8'h5d, 8'hff, 8'h03);
    rdchk(8'h5c, 8'hff, 8'h5a);
    $display("test overflow done");
    // Second hardware reset in mid-run, with a byte left in the FIFO
    i_overhead_bit_source.packet('{8'h66}, 1'b0);
    settle();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("tx C-bit in reset", {7'h0, txCbitInsert_r}, 8'h00);
    @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdchk(8'h55, 8'hff, 8'h00);
    rdchk(8'h57, 8'hff, 8'h20);
    $display("test hardware reset done");
    give_verdict();
  end
endmodule // testbench
bind hdlc_rx_ctrl hdlc_rx_ctrl_asserts i_hdlc_rx_ctrl_asserts (.clk_sys(clk_sys), .nrst(nrst), .frmMode(frmMode),
  .snSourceSel(snSourceSel), .txCbitInsert_r(txCbitInsert_r), .txSnInsert_r(txSnInsert_r), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r));
